/* logic/gos_top.v */
// Purpose: gate option sequencer, options and run control
// Assumes: APB slave, one clock, pins synchronised here
// Notes: motor drive and radio demod are outside
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "gos_consts.vh"
module gos_top #(
  parameter [31:0] CLK_HZ = `GOS_CLK_HZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [12:0] pins_in,
  input wire [1:0] ob_act,
  input wire [1:0] ob_miss,
  output reg motor_open,
  output reg motor_close,
  output reg service_due_lamp,
  output reg alarm_beep,
  output reg peer_link,
  output reg [7:0] err_code
);
  // --------------------------------------------------
  // Pin inputs
  // --------------------------------------------------
  // pins_in: 0 open_btn 1 close_btn 2 stop 3 fire 4 enter 5 shadow
  // 6 reverse_loop 7 open_limit 8 close_limit 9 obs_open 10 obs_close
  // 11 peer_link_in 12 cycle_done
  wire [12:0] pin_s;
  wire tick;
  gos_sync #(.W(13)) u_sync (.pclk(pclk), .presetn(presetn), .din(pins_in), .dout(pin_s));
  gos_tick #(.CLK_HZ(CLK_HZ)) u_tick (.pclk(pclk), .presetn(presetn), .tick(tick));
  wire b_open = pin_s[0];
  wire b_close = pin_s[1];
  wire b_stop = pin_s[2];
  wire fire = pin_s[3];
  wire b_enter = pin_s[4];
  wire shadow = pin_s[5];
  wire rev_loop = pin_s[6];
  wire lim_open = pin_s[7];
  wire lim_close = pin_s[8];
  wire obs_open = pin_s[9];
  wire obs_close = pin_s[10];
  wire peer_in = pin_s[11];
  wire cyc_done = pin_s[12];
  // --------------------------------------------------
  // Registers
  // --------------------------------------------------
  reg [31:0] cfg_r, time_r, cyc_r, svc_r;
  reg [5:0] tx_cnt_r;
  reg [1:0] ob_cnt_r, miss0_r, miss1_r;
  reg [6:0] mid_s_r, stg_s_r;
  reg [3:0] edge_r;
  reg show_cyc_r, stg_wait_r, shadow_d_r, peer_d_r, cyc_d_r;
  reg [2:0] st_r, st_nxt;
  wire wr = psel && penable && pwrite;
  wire rd = psel && !penable && !pwrite;
  wire [7:0] cmd = (wr && paddr == `GOS_OFF_CMD) ? pwdata[7:0] : 8'h00;
  wire hold_open = cfg_r[`GOS_CFG_HOLD_OPEN];
  wire hold_close = cfg_r[`GOS_CFG_HOLD_CLOSE];
  wire dual = cfg_r[`GOS_CFG_DUAL];
  wire radio_en = cfg_r[`GOS_CFG_RADIO_EN];
  wire [2:0] gtype = cfg_r[`GOS_CFG_GTYPE_HI:`GOS_CFG_GTYPE_LO];
  wire [6:0] mid_t = time_r[6:0];
  wire [6:0] stg_t = time_r[14:8];
  // States, one-hot
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_OPEN = 3'b010;
  localparam [2:0] S_CLOSE = 3'b100;
  // Supervision need by gate type; paired second unit needs open only
  wire need_o = gtype == 3'd0 || gtype == 3'd3 || gtype == 3'd4;
  wire need_c = (need_o || gtype == 3'd5) && !cfg_r[`GOS_CFG_PAIRED2];
  // Obstacle tx roles: 0 open obs 1 close obs 2 reverse 3 stop
  wire [1:0] role0 = cfg_r[`GOS_CFG_OB0_HI:`GOS_CFG_OB0_LO];
  wire [1:0] role1 = cfg_r[`GOS_CFG_OB1_HI:`GOS_CFG_OB1_LO];
  wire a0 = ob_act[0] && radio_en && ob_cnt_r != 2'd0;
  wire a1 = ob_act[1] && radio_en && ob_cnt_r == 2'd2;
  wire tx_oo = (a0 && role0 == 2'd0) || (a1 && role1 == 2'd0);
  wire tx_oc = (a0 && role0 == 2'd1) || (a1 && role1 == 2'd1);
  wire tx_rv = (a0 && role0 == 2'd2) || (a1 && role1 == 2'd2);
  wire tx_st = (a0 && role0 == 2'd3) || (a1 && role1 == 2'd3);
  // Held direction skips the supervision demand
  wire sup_o_ok = hold_open || !need_o || obs_open || tx_oo;
  wire sup_c_ok = hold_close || !need_c || obs_close || tx_oc;
  // High supervised input means healthy; a drop while demanded is an obstruction
  wire obs_o_hit = need_o && !hold_open && !obs_open;
  wire obs_c_hit = need_c && !hold_close && !obs_close;
  wire any_rev = rev_loop || tx_rv || obs_c_hit || tx_oc;
  // --------------------------------------------------
  // Run control
  // --------------------------------------------------
  wire shadow_clr = shadow_d_r && !shadow;
  wire peer_rise = peer_in && !peer_d_r;
  wire open_req = b_open || (peer_rise && dual);
  wire open_ok = !(lim_close && shadow && cfg_r[`GOS_CFG_SHADOW_OPEN]);
  wire close_ok = !(lim_open && shadow);
  wire tg = cfg_r[`GOS_CFG_TAILGATE];
  wire mid_on = mid_t != 7'h00 && !dual;
  wire full_ovr = fire || edge_r[0] || edge_r[1];
  // Next state
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE:
      begin
        // Fire at the open limit rests here rather than toggling the motor
        if (fire)
          st_nxt = lim_open ? S_IDLE : S_OPEN;
        else if (b_stop || tx_st)
          st_nxt = S_IDLE;
        else if (open_req && open_ok && sup_o_ok && !lim_open && !stg_wait_r)
          st_nxt = S_OPEN;
        else if (b_close && close_ok && sup_c_ok && !lim_close)
          st_nxt = S_CLOSE;
        else if (tg && shadow_clr && lim_open && sup_c_ok)
          st_nxt = S_CLOSE;
      end
      S_OPEN:
      begin
        if (lim_open)
          st_nxt = S_IDLE;
        else if (fire)
          st_nxt = S_OPEN;
        else if (b_stop || tx_st || tx_oo || obs_o_hit)
          st_nxt = S_IDLE;
        else if (hold_open && !b_open)
          st_nxt = S_IDLE;
        else if (b_close && close_ok)
          st_nxt = S_CLOSE;
        else if (mid_on && !full_ovr && !b_open && mid_s_r >= mid_t)
          st_nxt = S_IDLE;
      end
      S_CLOSE:
      begin
        if (lim_close)
          st_nxt = S_IDLE;
        else if (fire || any_rev)
          st_nxt = S_OPEN;
        else if (b_stop || tx_st)
          st_nxt = S_IDLE;
        else if (hold_close && !b_close)
          st_nxt = S_IDLE;
      end
      default:
        st_nxt = S_IDLE;
    endcase
  end
  // State, timers, motor outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= S_IDLE;
      edge_r <= 4'h0;
      mid_s_r <= 7'h00;
      stg_s_r <= 7'h00;
      stg_wait_r <= 1'b0;
      shadow_d_r <= 1'b0;
      peer_d_r <= 1'b0;
      cyc_d_r <= 1'b0;
      motor_open <= 1'b0;
      motor_close <= 1'b0;
      peer_link <= 1'b0;
    end
    else
    begin
      shadow_d_r <= shadow;
      peer_d_r <= peer_in;
      cyc_d_r <= cyc_done;
      st_r <= st_nxt;
      // Stagger wait counted in whole seconds from the peer edge; the peer open starts at once, the wait blocks later open requests
      if (dual && peer_rise && stg_t != 7'h00 && st_r == S_IDLE)
      begin
        stg_wait_r <= 1'b1;
        stg_s_r <= 7'h00;
      end
      else if (stg_wait_r && tick)
      begin
        if (stg_s_r + 7'd1 >= stg_t)
          stg_wait_r <= 1'b0;
        stg_s_r <= stg_s_r + 7'd1;
      end
      // Sticky override reasons for the current opening
      if (st_r != S_OPEN)
      begin
        mid_s_r <= 7'h00;
        edge_r <= {2'b00, any_rev, 1'b0};
      end
      else
      begin
        if (tick && mid_s_r != `GOS_TIME_MAX)
          mid_s_r <= mid_s_r + 7'd1;
        if (b_open && mid_s_r >= mid_t)
          edge_r[0] <= 1'b1;
        if (any_rev)
          edge_r[1] <= 1'b1;
      end
      // Tailgate halt: shadow stops closing, resumes when clear
      motor_open <= st_nxt == S_OPEN;
      motor_close <= st_nxt == S_CLOSE && !(tg && shadow);
      // Activation pulse to the peer
      peer_link <= dual && st_r == S_IDLE && st_nxt != S_IDLE && !peer_rise;
    end
  end
  // without tailgate, shadow_clr never starts a close above
  // --------------------------------------------------
  // Counters, radio memory, alarms
  // --------------------------------------------------
  wire [31:0] svc_lim = (cfg_r[`GOS_CFG_SVC_HI:`GOS_CFG_SVC_LO] == 2'd0) ? 32'd5000 :
    (cfg_r[`GOS_CFG_SVC_HI:`GOS_CFG_SVC_LO] == 2'd1) ? 32'd10000 :
    (cfg_r[`GOS_CFG_SVC_HI:`GOS_CFG_SVC_LO] == 2'd2) ? 32'd15000 : 32'd25000;
  reg [31:0] hold_cyc_r;
  wire clr_full = show_cyc_r && b_enter && hold_cyc_r >= `GOS_HOLD_CLR_S * CLK_HZ - 32'd1;
  wire cyc_inc = cyc_done && !cyc_d_r;
  wire svc_wr = wr && paddr == `GOS_OFF_CFG;
  wire [31:0] cfg_def_keep = (`GOS_CFG_DEFAULT & 32'hFFF0FFFF) | (cfg_r & 32'h000F0000);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_r <= 32'h00000000;
      svc_r <= 32'h00000000;
      hold_cyc_r <= 32'h00000000;
      service_due_lamp <= 1'b0;
      tx_cnt_r <= 6'h00;
      ob_cnt_r <= 2'h0;
      miss0_r <= 2'h0;
      miss1_r <= 2'h0;
      alarm_beep <= 1'b0;
    end
    else
    begin
      // Enter hold timed against the cycle display
      if (!(b_enter && show_cyc_r) || clr_full)
        hold_cyc_r <= 32'h00000000;
      else
        hold_cyc_r <= hold_cyc_r + 32'd1;
      // Clear wins over a count landing in the same cycle
      if (clr_full)
        cyc_r <= 32'h00000000;
      else if (cyc_inc)
        cyc_r <= cyc_r + 32'd1;
      if (clr_full || cmd[`GOS_CMD_CLR_SVC])
        svc_r <= 32'h00000000;
      else if (cyc_inc)
        svc_r <= svc_r + 32'd1;
      service_due_lamp <= !(clr_full || cmd[`GOS_CMD_CLR_SVC]) && svc_r > svc_lim;
      // Transmitter memory, learn hidden when full or radio off
      if (cmd[`GOS_CMD_DEL_ALL] && tx_cnt_r != 6'h00 && radio_en)
        tx_cnt_r <= 6'h00;
      else if (cmd[`GOS_CMD_DEL_TX] && tx_cnt_r != 6'h00 && radio_en)
        tx_cnt_r <= tx_cnt_r - 6'd1;
      else if (cmd[`GOS_CMD_LEARN_TX] && tx_cnt_r < `GOS_TX_MAX && radio_en)
        tx_cnt_r <= tx_cnt_r + 6'd1;
      if (cmd[`GOS_CMD_DEL_OB] && ob_cnt_r != 2'd0 && radio_en)
        ob_cnt_r <= 2'd0;
      else if (cmd[`GOS_CMD_LEARN_OB] && ob_cnt_r < 2'd2 && radio_en)
        ob_cnt_r <= ob_cnt_r + 2'd1;
      // Consecutive misses; a heard report resets the run
      if (ob_act[0])
        miss0_r <= 2'h0;
      else if (ob_miss[0] && miss0_r != `GOS_MISS_LIMIT)
        miss0_r <= miss0_r + 2'd1;
      if (ob_act[1])
        miss1_r <= 2'h0;
      else if (ob_miss[1] && miss1_r != `GOS_MISS_LIMIT)
        miss1_r <= miss1_r + 2'd1;
      alarm_beep <= cfg_r[`GOS_CFG_MON_EN] &&
        ((ob_cnt_r != 2'd0 && miss0_r == `GOS_MISS_LIMIT) ||
         (ob_cnt_r == 2'd2 && miss1_r == `GOS_MISS_LIMIT));
    end
  end
  // --------------------------------------------------
  // APB slave
  // --------------------------------------------------
  wire illegal = mid_t > `GOS_TIME_MAX || stg_t > `GOS_TIME_MAX || gtype > 3'd5;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= `GOS_CFG_DEFAULT;
      time_r <= `GOS_TIME_DEFAULT;
      show_cyc_r <= 1'b0;
      err_code <= 8'h00;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (cmd[`GOS_CMD_DEFAULTS])
      begin
        cfg_r <= cfg_def_keep;
        time_r <= `GOS_TIME_DEFAULT;
      end
      else if (cmd[`GOS_CMD_EXIT_PROG] && illegal)
      begin
        err_code <= `GOS_ERR_CODE;
        time_r <= 32'h00000000;
        cfg_r[`GOS_CFG_GTYPE_HI:`GOS_CFG_GTYPE_LO] <= 3'd0;
      end
      else if (svc_wr)
        cfg_r <= pwdata & `GOS_CFG_MASK;
      else if (wr && paddr == `GOS_OFF_TIME)
        time_r <= {17'h00000, pwdata[14:8], 1'b0, pwdata[6:0]};
      if (cmd[`GOS_CMD_EXIT_PROG] && !illegal)
        err_code <= 8'h00;
      if (wr && paddr == `GOS_OFF_STAT)
        show_cyc_r <= pwdata[0];
      if (psel && !penable && !(paddr <= `GOS_OFF_RADIO && paddr[1:0] == 2'b00))
        pslverr <= 1'b1;
      if (rd)
      begin
        case (paddr)
          `GOS_OFF_CFG: prdata <= cfg_r;
          `GOS_OFF_TIME: prdata <= time_r;
          `GOS_OFF_STAT: prdata <= {16'h0000, err_code, 1'b0, alarm_beep,
            service_due_lamp, stg_wait_r, st_r, show_cyc_r};
          `GOS_OFF_CYC: prdata <= cyc_r;
          `GOS_OFF_SVC: prdata <= svc_r;
          `GOS_OFF_RADIO: prdata <= {20'h00000,
            radio_en && ob_cnt_r != 2'd0, radio_en && ob_cnt_r < 2'd2,
            radio_en && tx_cnt_r != 6'h00, radio_en && tx_cnt_r < `GOS_TX_MAX,
            ob_cnt_r, tx_cnt_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // gos_top
`default_nettype wire

/* logic/gos_consts.vh */
// Purpose: constants for the gate option sequencer
// Assumes: 50 MHz pclk
// Notes: APB byte offsets, field positions, defaults
`ifndef GOS_CONSTS_VH
`define GOS_CONSTS_VH
// --------------------------------------------------
// Register offsets
// --------------------------------------------------
`define GOS_OFF_CFG 12'h000
`define GOS_OFF_TIME 12'h004
`define GOS_OFF_CMD 12'h008
`define GOS_OFF_STAT 12'h00C
`define GOS_OFF_CYC 12'h010
`define GOS_OFF_SVC 12'h014
`define GOS_OFF_RADIO 12'h018
// --------------------------------------------------
// Config fields (CFG)
// --------------------------------------------------
`define GOS_CFG_HOLD_OPEN 0
`define GOS_CFG_HOLD_CLOSE 1
`define GOS_CFG_SHADOW_OPEN 2
`define GOS_CFG_TAILGATE 3
`define GOS_CFG_RADIO_EN 4
`define GOS_CFG_MON_EN 5
`define GOS_CFG_DUAL 6
`define GOS_CFG_PAIRED2 7
`define GOS_CFG_SVC_LO 8
`define GOS_CFG_SVC_HI 9
`define GOS_CFG_GTYPE_LO 12
`define GOS_CFG_GTYPE_HI 14
`define GOS_CFG_OB0_LO 16
`define GOS_CFG_OB0_HI 17
`define GOS_CFG_OB1_LO 18
`define GOS_CFG_OB1_HI 19
`define GOS_CFG_DEFAULT 32'h00000110
`define GOS_CFG_MASK 32'h000F73FF
// --------------------------------------------------
// Time fields (TIME): mid stop [6:0], stagger [14:8]
// --------------------------------------------------
`define GOS_TIME_DEFAULT 32'h00000000
`define GOS_TIME_MAX 7'h63
// --------------------------------------------------
// Command bits (CMD, write one)
// --------------------------------------------------
`define GOS_CMD_DEFAULTS 0
`define GOS_CMD_EXIT_PROG 1
`define GOS_CMD_CLR_SVC 2
`define GOS_CMD_LEARN_TX 3
`define GOS_CMD_DEL_TX 4
`define GOS_CMD_DEL_ALL 5
`define GOS_CMD_LEARN_OB 6
`define GOS_CMD_DEL_OB 7
// --------------------------------------------------
// Misc
// --------------------------------------------------
`define GOS_ERR_CODE 8'h15
`define GOS_TX_MAX 6'h28
`define GOS_HOLD_CLR_S 2
`define GOS_MISS_LIMIT 2'h2
`define GOS_CLK_HZ 50000000
`endif

/* logic/gos_sync.v */
// Purpose: three-stage pin synchroniser with agree filter
// Assumes: input asynchronous to pclk
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module gos_sync #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;
  // Per bit: first stage only feeds second
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          dout[i] <= 1'b0;
        end
        else
        begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i])
            dout[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule // gos_sync
`default_nettype wire

/* logic/gos_tick.v */
// Purpose: one-second tick from pclk
// Assumes: CLK_HZ cycles per second
// Notes: one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module gos_tick #(
  parameter [31:0] CLK_HZ = 32'd50000000
) (
  input wire pclk,
  input wire presetn,
  output reg tick
);
  reg [31:0] cnt_r;
  // Free-running divider
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 32'h00000000;
      tick <= 1'b0;
    end
    else if (cnt_r >= CLK_HZ - 32'd1)
    begin
      cnt_r <= 32'h00000000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'd1;
      tick <= 1'b0;
    end
  end
endmodule // gos_tick
`default_nettype wire

/* sim/gos_top_asserts.sv */
// Purpose: port-level checks for the gate option sequencer
// Assumes: one pclk domain, presetn async active low
// Notes: pin-driven checks wait for the synchroniser to settle
`timescale 1ns/1ps
`default_nettype none
module gos_chk #(
  parameter [31:0] CLK_HZ = 32'd50000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [12:0] pins_in,
  input wire logic [1:0] ob_act,
  input wire logic [1:0] ob_miss,
  input wire logic motor_open,
  input wire logic motor_close,
  input wire logic service_due_lamp,
  input wire logic alarm_beep,
  input wire logic peer_link,
  input wire logic [7:0] err_code
);
  // ----------------------------------------
  // Sequences and assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bad address: above the map or not word aligned
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done_bad;
    psel && penable && pready && (paddr > 12'h018 || paddr[1:0] != 2'h0);
  endsequence
  sequence s_done_good;
    psel && penable && pready && paddr <= 12'h018 && paddr[1:0] == 2'h0;
  endsequence
  // Eight cycles covers the three-flop synchroniser plus output register
  sequence s_open_shadow;
    (pins_in[7] && pins_in[5]) [*8];
  endsequence
  a_setup_gets_ready: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_bad_addr_err: assert property (s_done_bad |-> pslverr)
    else $error("pslverr missing on bad address");
  a_good_addr_ok: assert property (s_done_good |-> !pslverr)
    else $error("pslverr on mapped address");
  a_motor_exclusive: assert property (!(motor_open && motor_close))
    else $error("both motor directions on");
  a_shadow_no_close: assert property (s_open_shadow |-> !motor_close)
    else $error("close while open with shadow loop");
  a_peer_pulse_once: assert property ($rose(peer_link) |=> !peer_link)
    else $error("peer pulse longer than one cycle");
  a_err_code_15: assert property (err_code != 8'h00 |-> err_code == 8'h15)
    else $error("unexpected error code");
endmodule // gos_chk
bind gos_top gos_chk #(.CLK_HZ(CLK_HZ)) i_gos_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .ob_act(ob_act),
  .ob_miss(ob_miss), .motor_open(motor_open), .motor_close(motor_close),
  .service_due_lamp(service_due_lamp), .alarm_beep(alarm_beep),
  .peer_link(peer_link), .err_code(err_code)
);
`default_nettype wire

/* sim/gos_field.sv */
// Purpose: field model: gate travel, limits, buttons and loops
// Assumes: motor outputs are levels
// Notes: limit bits come from position; the rest from the bench
`timescale 1ns/1ps
`default_nettype none
module gos_field #(
  parameter int TRAVEL = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic motor_open,
  input wire logic motor_close,
  input wire logic [12:0] ctl,
  output logic [12:0] pins_in
);
  // ----------------------------------------
  // Gate position
  // ----------------------------------------
  logic [7:0] pos_r;
  // One step per cycle keeps runs short but still spans mid stops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos_r <= 8'h00;
    else if (motor_open && pos_r < 8'(TRAVEL))
      pos_r <= pos_r + 8'h01;
    else if (motor_close && pos_r > 8'h00)
      pos_r <= pos_r - 8'h01;
  end
  // Limit switches replace bench bits 8 and 7
  assign pins_in = {ctl[12:9], pos_r == 8'h00, pos_r == 8'(TRAVEL), ctl[6:0]};
endmodule // gos_field
`default_nettype wire

/* sim/gate_option_sequencer_tb_top.sv */
// Purpose: self-checking bench for the gate option sequencer
// Assumes: CLK_HZ of 10, so one second is ten cycles
// Notes: field model moves the gate one step per cycle
`timescale 1ns/1ps
`default_nettype none
module gate_option_sequencer_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [12:0] ctl = 13'h0600, pins_in;
  logic [1:0] ob_act = 2'h0, ob_miss = 2'h0;
  logic pready, pslverr, motor_open, motor_close, lamp, alarm, peer_link, peer_seen = 1'b0;
  logic [7:0] err_code;
  int errors = 0, checks = 0, cyc = 0;
  gos_top #(.CLK_HZ(32'd10)) i_gos_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
    .ob_act(ob_act), .ob_miss(ob_miss), .motor_open(motor_open),
    .motor_close(motor_close), .service_due_lamp(lamp), .alarm_beep(alarm),
    .peer_link(peer_link), .err_code(err_code));
  gos_field #(.TRAVEL(40)) i_gos_field (.pclk(pclk), .presetn(presetn),
    .motor_open(motor_open), .motor_close(motor_close), .ctl(ctl), .pins_in(pins_in));
  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  always #10 pclk = ~pclk;
  // Peer pulse lasts one cycle, so latch it
  always @(posedge pclk)
  begin
    cyc++;
    if (peer_link === 1'b1) peer_seen <= 1'b1;
    if (cyc == 20000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // APB transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = pslverr ? 32'hFFFFFFFF : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // Wait a bounded time for a motor output to reach a level
  task automatic wmot(input bit cl, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && (cl ? motor_close : motor_open) !== v; i++) @(posedge pclk);
    chk(cl ? "motor_close" : "motor_open", {31'h0, v}, {31'h0, cl ? motor_close : motor_open});
  endtask
  task automatic press(input int b, input int n);
    @(posedge pclk);
    ctl[b] <= 1'b1;
    repeat (n) @(posedge pclk);
    ctl[b] <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_regs();
    rdc("cfg", 12'h000, 32'h00000110);
    rdc("time", 12'h004, 32'h00000000);
    rdc("radio", 12'h018, 32'h00000500);
    rdc("unmapped", 12'h01C, 32'hFFFFFFFF);
    apb(1'b1, 12'h000, 32'h000F0011);
    rdc("cfg", 12'h000, 32'h000F0011);
    apb(1'b1, 12'h008, 32'h00000001);
    rdc("cfg", 12'h000, 32'h000F0110);
    apb(1'b1, 12'h004, 32'h0000007F);
    apb(1'b1, 12'h000, 32'h00007110);
    apb(1'b1, 12'h008, 32'h00000002);
    @(posedge pclk);
    chk("err_code", 32'h15, {24'h0, err_code});
    rdc("time", 12'h004, 32'h00000000);
    rdc("cfg", 12'h000, 32'h00000110);
  endtask
  task automatic s_learn();
    repeat (3) apb(1'b1, 12'h008, 32'h00000040);
    repeat (2) apb(1'b1, 12'h008, 32'h00000008);
    apb(1'b1, 12'h008, 32'h00000010);
    rdc("radio", 12'h018, 32'h00000B81);
    apb(1'b1, 12'h008, 32'h00000020);
    rdc("radio", 12'h018, 32'h00000980);
    apb(1'b1, 12'h000, 32'h00000100);
    rdc("radio", 12'h018, 32'h00000080);
    apb(1'b1, 12'h000, 32'h00000130);
    ob_miss <= 2'h1;
    @(posedge pclk);
    ob_miss <= 2'h0;
    repeat (4) @(posedge pclk);
    chk("alarm", 32'h0, {31'h0, alarm});
    ob_miss <= 2'h1;
    @(posedge pclk);
    ob_miss <= 2'h0;
    repeat (4) @(posedge pclk);
    chk("alarm", 32'h1, {31'h0, alarm});
    apb(1'b1, 12'h000, 32'h00000110);
  endtask
  task automatic s_runs();
    press(0, 8);
    wmot(0, 1'b1, 12);
    repeat (10) @(posedge pclk);
    chk("run_on", 32'h1, {31'h0, motor_open});
    wmot(0, 1'b0, 60);
    chk("open_lim", 32'h1, {31'h0, pins_in[7]});
    press(1, 8);
    wmot(1, 1'b0, 70);
    apb(1'b1, 12'h000, 32'h00000113);
    ctl <= 13'h0001;
    wmot(0, 1'b1, 12);
    repeat (10) @(posedge pclk);
    ctl <= 13'h0000;
    wmot(0, 1'b0, 12);
    chk("mid_pos", 32'h0, {30'h0, pins_in[8:7]});
    ctl <= 13'h0002;
    repeat (60) @(posedge pclk);
    ctl <= 13'h0600;
    apb(1'b1, 12'h000, 32'h00000110);
  endtask
  task automatic s_shadow();
    press(0, 8);
    wmot(0, 1'b0, 70);
    ctl[5] <= 1'b1;
    press(1, 8);
    repeat (6) @(posedge pclk);
    chk("close_blk", 32'h0, {31'h0, motor_close});
    ctl[5] <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("no_tail", 32'h0, {31'h0, motor_close});
    apb(1'b1, 12'h000, 32'h00000118);
    press(5, 8);
    wmot(1, 1'b1, 12);
    press(5, 8);
    wmot(1, 1'b0, 12);
    wmot(1, 1'b1, 12);
    wmot(1, 1'b0, 60);
    apb(1'b1, 12'h004, 32'h00000002);
    press(0, 8);
    wmot(0, 1'b0, 60);
    chk("mid_stop", 32'h0, {30'h0, pins_in[8:7]});
    press(1, 8);
    wmot(1, 1'b0, 60);
    apb(1'b1, 12'h000, 32'h00000150);
    press(0, 8);
    wmot(0, 1'b0, 70);
    chk("dual_full", 32'h1, {31'h0, pins_in[7]});
    chk("peer", 32'h1, {31'h0, peer_seen});
    press(1, 8);
    wmot(1, 1'b0, 70);
    press(11, 8);
    wmot(0, 1'b1, 12);
  endtask
  task automatic s_count();
    // Gap of several cycles so the pin filter sees each falling edge
    repeat (3)
    begin
      press(12, 8);
      repeat (4) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
    rdc("cyc", 12'h010, 32'h00000003);
    apb(1'b1, 12'h008, 32'h00000004);
    rdc("svc", 12'h014, 32'h00000000);
    rdc("cyc", 12'h010, 32'h00000003);
    apb(1'b1, 12'h00C, 32'h00000001);
    press(4, 30);
    repeat (4) @(posedge pclk);
    rdc("cyc", 12'h010, 32'h00000000);
    chk("lamp", 32'h0, {31'h0, lamp});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_learn();
    s_runs();
    s_count();
    s_shadow();
    conclude();
  end
endmodule // gate_option_sequencer_tb_top
`default_nettype wire
